// file: design/sfd_consts.vh
// opcodes, command kinds and limits for the serial flash instruction decoder
`ifndef SFD_CONSTS_VH
`define SFD_CONSTS_VH
`define SFD_OP_WREN   8'h06
`define SFD_OP_WRVOL  8'h50
`define SFD_OP_WRDI   8'h04
`define SFD_OP_RDSR   8'h05
`define SFD_OP_WRSR   8'h01
`define SFD_OP_READ   8'h03
`define SFD_OP_FAST   8'h0B
`define SFD_OP_DOUT   8'h3B
`define SFD_OP_DIO    8'hBB
`define SFD_OP_PROG   8'h02
`define SFD_OP_SE4    8'h20
`define SFD_OP_BE32   8'h52
`define SFD_OP_BE64   8'hD8
`define SFD_OP_CE1    8'hC7
`define SFD_OP_CE2    8'h60
`define SFD_OP_PD     8'hB9
`define SFD_OP_RPD    8'hAB
`define SFD_OP_MFID   8'h90
`define SFD_OP_MFDIO  8'h92
`define SFD_OP_JID    8'h9F
`define SFD_OP_UID    8'h4B
`define SFD_K_NONE    4'h0
`define SFD_K_SIMPLE  4'h1
`define SFD_K_STAT    4'h2
`define SFD_K_WRST    4'h3
`define SFD_K_READ    4'h4
`define SFD_K_FAST    4'h5
`define SFD_K_DOUT    4'h6
`define SFD_K_DIO     4'h7
`define SFD_K_PROG    4'h8
`define SFD_K_ERASE   4'h9
`define SFD_K_RDPD    4'hA
`define SFD_K_MFID    4'hB
`define SFD_K_MFDIO   4'hC
`define SFD_K_JID     4'hD
`define SFD_K_UID     4'hE
`define SFD_LEN_BYTE  6'h08
`define SFD_LEN_ADDR  6'h18
`define SFD_LEN_ADDX  6'h20
`define SFD_PAGE_MAX  9'h100
`define SFD_IDX_MAX   4'hF
`endif

// file: design/sfd_decoder.v
// serial flash instruction framing, decoding and read-back shifter
// Contract
// - 06h, 50h, 04h are lone opcode bytes
// - 05h repeats status byte while selected
// - 01h takes exactly one status byte
// - 03h, three address bytes, endless data
// - 0Bh adds one dummy byte, single line
// - 3Bh streams data on two lines
// - odd bits upper line, even bits lower
// - BBh takes address and mode on two lines
// - 02h, address, at most 256 data bytes
// - 20h, 52h, D8h take exactly three address bytes
// - C7h or 60h erase whole array
// - B9h sleeps, ABh wakes and returns identifier
// - identifier repeats until deselect
// - 90h answers manufacturer then device byte
// - 92h does the same over two lines
// - 9Fh returns manufacturer, type, capacity
// - 4Bh, four dummies, 64-bit unique identifier
// - every byte moves most significant first
// - select low frames, first byte is opcode
// - input sampled on serial clock rise
// - writes need whole bytes, reads need not
// - while busy only status read is taken
`timescale 1ns/1ns
`include "sfd_consts.vh"
module sfd_decoder #(
   parameter [7:0]  MFR_ID    = 8'hA5,                 // arbitrary value
   parameter [7:0]  DEV_ID    = 8'h5A,                 // arbitrary value
   parameter [7:0]  MEM_TYPE  = 8'h3C,                 // arbitrary value
   parameter [7:0]  CAPACITY  = 8'hC3,                 // arbitrary value
   parameter [63:0] UNIQUE_ID = 64'h0123_4567_89AB_CDEF // arbitrary value
) (
   input  wire        i_clk,
   input  wire        i_rst,
   input  wire        i_cs_n,
   input  wire        i_sclk,
   input  wire        i_dual_line_lower,
   input  wire        i_dual_line_upper,
   input  wire        i_busy,
   input  wire [7:0]  i_status,
   input  wire [7:0]  i_rd_data,
   output reg         o_dual_line_lower,
   output reg         o_dual_line_lower_oe,
   output reg         o_dual_line_upper,
   output reg         o_dual_line_upper_oe,
   output reg  [23:0] o_rd_addr,
   output reg         o_pg_wr,
   output reg  [7:0]  o_pg_data,
   output reg  [7:0]  o_pg_index,
   output reg         o_cmd_valid,
   output reg  [7:0]  o_cmd_op,
   output reg  [23:0] o_cmd_addr,
   output reg  [7:0]  o_cmd_wdata,
   output reg  [8:0]  o_cmd_count,
   output reg  [7:0]  o_mode_bits,
   output reg         o_power_down
);
   localparam [5:0] ST_OP   = 6'h01;
   localparam [5:0] ST_IN   = 6'h02;
   localparam [5:0] ST_WDAT = 6'h04;
   localparam [5:0] ST_OUT  = 6'h08;
   localparam [5:0] ST_DONE = 6'h10;
   localparam [5:0] ST_IGN  = 6'h20;

   reg  [2:0]  sclk_s_r;
   reg  [2:0]  cs_s_r;
   reg  [1:0]  lo_s_r;
   reg  [1:0]  up_s_r;
   reg  [5:0]  state_r;
   reg  [3:0]  kind_r;
   reg  [7:0]  op_r;
   reg  [31:0] sh_r;
   reg  [5:0]  cnt_r;
   reg  [2:0]  bcnt_r;
   reg         bad_r;
   reg         done_r;
   reg  [7:0]  wdata_r;
   reg  [8:0]  pgcnt_r;
   reg  [2:0]  pos_r;
   reg  [3:0]  idx_r;
   reg  [7:0]  obyte_r;
   reg  [3:0]  dec_k;
   reg  [7:0]  cur_byte;

   // opcode to command kind
   function [3:0] decode;
      input [7:0] op;
      begin
         case (op)
            `SFD_OP_WREN, `SFD_OP_WRVOL, `SFD_OP_WRDI: decode = `SFD_K_SIMPLE;
            `SFD_OP_CE1, `SFD_OP_CE2: decode = `SFD_K_SIMPLE;
            `SFD_OP_PD:    decode = `SFD_K_SIMPLE;
            `SFD_OP_RDSR:  decode = `SFD_K_STAT;
            `SFD_OP_WRSR:  decode = `SFD_K_WRST;
            `SFD_OP_READ:  decode = `SFD_K_READ;
            `SFD_OP_FAST:  decode = `SFD_K_FAST;
            `SFD_OP_DOUT:  decode = `SFD_K_DOUT;
            `SFD_OP_DIO:   decode = `SFD_K_DIO;
            `SFD_OP_PROG:  decode = `SFD_K_PROG;
            `SFD_OP_SE4, `SFD_OP_BE32, `SFD_OP_BE64: decode = `SFD_K_ERASE;
            `SFD_OP_RPD:   decode = `SFD_K_RDPD;
            `SFD_OP_MFID:  decode = `SFD_K_MFID;
            `SFD_OP_MFDIO: decode = `SFD_K_MFDIO;
            `SFD_OP_JID:   decode = `SFD_K_JID;
            `SFD_OP_UID:   decode = `SFD_K_UID;
            default:       decode = `SFD_K_NONE;
         endcase
      end
   endfunction

   // bits the host sends after the opcode
   function [5:0] plen;
      input [3:0] k;
      begin
         case (k)
            `SFD_K_WRST: plen = `SFD_LEN_BYTE;
            `SFD_K_READ, `SFD_K_PROG, `SFD_K_ERASE: plen = `SFD_LEN_ADDR;
            `SFD_K_RDPD, `SFD_K_MFID: plen = `SFD_LEN_ADDR;
            `SFD_K_FAST, `SFD_K_DOUT, `SFD_K_UID: plen = `SFD_LEN_ADDX;
            `SFD_K_DIO, `SFD_K_MFDIO: plen = `SFD_LEN_ADDX;
            default: plen = 6'h00;
         endcase
      end
   endfunction

   // address and mode arrive on both lines
   function dual_in;
      input [3:0] k;
      begin
         dual_in = (k == `SFD_K_DIO) || (k == `SFD_K_MFDIO);
      end
   endfunction

   // data leaves on both lines
   function dual_out;
      input [3:0] k;
      begin
         dual_out = dual_in(k) || (k == `SFD_K_DOUT);
      end
   endfunction

   // commands that change the array, status or power state and need whole bytes
   function is_wr;
      input [3:0] k;
      begin
         is_wr = (k == `SFD_K_SIMPLE) || (k == `SFD_K_WRST) ||
                 (k == `SFD_K_PROG) || (k == `SFD_K_ERASE);
      end
   endfunction

   // byte to shift out for read-back index idx
   function [7:0] pick;
      input [3:0] k;
      input [3:0] idx;
      reg   [63:0] tmp;
      begin
         tmp = UNIQUE_ID >> {3'd7 - idx[2:0], 3'b000};
         case (k)
            `SFD_K_STAT: pick = i_status;
            `SFD_K_READ, `SFD_K_FAST, `SFD_K_DOUT, `SFD_K_DIO: pick = i_rd_data;
            `SFD_K_RDPD: pick = DEV_ID;
            `SFD_K_MFID, `SFD_K_MFDIO: pick = idx[0] ? DEV_ID : MFR_ID;
            `SFD_K_JID: begin
               if (idx == 4'h0) begin
                  pick = MFR_ID;
               end else if (idx == 4'h1) begin
                  pick = MEM_TYPE;
               end else if (idx == 4'h2) begin
                  pick = CAPACITY;
               end else begin
                  pick = 8'h00;
               end
            end
            `SFD_K_UID: pick = idx[3] ? 8'h00 : tmp[7:0];
            default: pick = 8'h00;
         endcase
      end
   endfunction

   // synchronised pins and their edges
   wire        sclk_rise = sclk_s_r[1] & ~sclk_s_r[2];
   wire        sclk_fall = ~sclk_s_r[1] & sclk_s_r[2];
   wire        cs_act    = ~cs_s_r[1];
   wire        cs_rise   = cs_s_r[1] & ~cs_s_r[2];
   wire        lo_in     = lo_s_r[1];
   wire        up_in     = up_s_r[1];
   wire        din       = (state_r == ST_IN) && dual_in(kind_r);
   wire        dout      = dual_out(kind_r);
   // msb-first shift, odd bit on the upper line when dual
   wire [31:0] shn       = din ? {sh_r[29:0], up_in, lo_in} :
                                 {sh_r[30:0], lo_in};
   wire [5:0]  cntn      = cnt_r + (din ? 6'h02 : 6'h01);
   wire [2:0]  bcntn     = bcnt_r + (din ? 3'h2 : 3'h1);
   wire        last_bit  = dout ? (pos_r == 3'h1) : (pos_r == 3'h0);
   wire        commit    = is_wr(kind_r) && done_r && !bad_r &&
                           (bcnt_r == 3'h0);

   // opcode gating for power-down and busy
   always @* begin
      dec_k = decode(shn[7:0]);
      if (o_power_down && (shn[7:0] != `SFD_OP_RPD)) begin
         dec_k = `SFD_K_NONE;
      end
      if (i_busy && (shn[7:0] != `SFD_OP_RDSR)) begin
         dec_k = `SFD_K_NONE;
      end
   end

   // byte held for the current output position
   always @* begin
      cur_byte = (pos_r == 3'h7) ? pick(kind_r, idx_r) : obyte_r;
   end

   // pin synchronisers, two flops each, a third on clock and select for edges
   always @(posedge i_clk) begin
      if (i_rst) begin
         sclk_s_r <= 3'h0;
         cs_s_r   <= 3'h7;
         lo_s_r   <= 2'h0;
         up_s_r   <= 2'h0;
      end else begin
         sclk_s_r <= {sclk_s_r[1:0], i_sclk};
         cs_s_r   <= {cs_s_r[1:0], i_cs_n};
         lo_s_r   <= {lo_s_r[0], i_dual_line_lower};
         up_s_r   <= {up_s_r[0], i_dual_line_upper};
      end
   end

   // instruction framing, decode, capture and shift-out
   always @(posedge i_clk) begin
      if (i_rst) begin
         state_r              <= ST_OP;
         kind_r               <= `SFD_K_NONE;
         op_r                 <= 8'h00;
         sh_r                 <= 32'h0000_0000;
         cnt_r                <= 6'h00;
         bcnt_r               <= 3'h0;
         bad_r                <= 1'b0;
         done_r               <= 1'b0;
         wdata_r              <= 8'h00;
         pgcnt_r              <= 9'h000;
         pos_r                <= 3'h7;
         idx_r                <= 4'h0;
         obyte_r              <= 8'h00;
         o_dual_line_lower    <= 1'b0;
         o_dual_line_lower_oe <= 1'b0;
         o_dual_line_upper    <= 1'b0;
         o_dual_line_upper_oe <= 1'b0;
         o_rd_addr            <= 24'h00_0000;
         o_pg_wr              <= 1'b0;
         o_pg_data            <= 8'h00;
         o_pg_index           <= 8'h00;
         o_cmd_valid          <= 1'b0;
         o_cmd_op             <= 8'h00;
         o_cmd_addr           <= 24'h00_0000;
         o_cmd_wdata          <= 8'h00;
         o_cmd_count          <= 9'h000;
         o_mode_bits          <= 8'h00;
         o_power_down         <= 1'b0;
      end else begin
         o_cmd_valid <= 1'b0;
         o_pg_wr     <= 1'b0;
         if (!cs_act) begin
            // deselect ends the frame and rearms for an opcode
            if (cs_rise && commit) begin
               o_cmd_valid <= 1'b1;
               o_cmd_op    <= op_r;
               o_cmd_addr  <= o_rd_addr;
               o_cmd_wdata <= wdata_r;
               o_cmd_count <= pgcnt_r;
               if (op_r == `SFD_OP_PD) begin
                  o_power_down <= 1'b1;
               end
            end
            state_r              <= ST_OP;
            kind_r               <= `SFD_K_NONE;
            cnt_r                <= 6'h00;
            bcnt_r               <= 3'h0;
            bad_r                <= 1'b0;
            done_r               <= 1'b0;
            pgcnt_r              <= 9'h000;
            pos_r                <= 3'h7;
            idx_r                <= 4'h0;
            o_dual_line_lower_oe <= 1'b0;
            o_dual_line_upper_oe <= 1'b0;
         end else if (sclk_rise) begin
            sh_r   <= shn;
            bcnt_r <= bcntn;
            case (state_r)
               ST_OP: begin
                  cnt_r <= cntn;
                  if (cntn == `SFD_LEN_BYTE) begin
                     cnt_r  <= 6'h00;
                     op_r   <= shn[7:0];
                     kind_r <= dec_k;
                     if (dec_k == `SFD_K_RDPD) begin
                        o_power_down <= 1'b0;
                     end
                     if (dec_k == `SFD_K_NONE) begin
                        state_r <= ST_IGN;
                     end else if (plen(dec_k) != 6'h00) begin
                        state_r <= ST_IN;
                     end else if (is_wr(dec_k)) begin
                        done_r  <= 1'b1;
                        state_r <= ST_DONE;
                     end else begin
                        state_r <= ST_OUT;
                     end
                  end
               end
               ST_IN: begin
                  cnt_r <= cntn;
                  if (cntn == plen(kind_r)) begin
                     cnt_r   <= 6'h00;
                     done_r  <= 1'b1;
                     wdata_r <= shn[7:0];
                     if (plen(kind_r) == `SFD_LEN_ADDR) begin
                        o_rd_addr <= shn[23:0];
                     end else begin
                        o_rd_addr <= shn[31:8];
                     end
                     if (dual_in(kind_r)) begin
                        o_mode_bits <= shn[7:0];
                     end
                     if (kind_r == `SFD_K_PROG) begin
                        state_r <= ST_WDAT;
                     end else if (is_wr(kind_r)) begin
                        state_r <= ST_DONE;
                     end else begin
                        state_r <= ST_OUT;
                     end
                  end
               end
               ST_WDAT: begin
                  cnt_r <= cntn;
                  if (cntn == `SFD_LEN_BYTE) begin
                     cnt_r <= 6'h00;
                     if (pgcnt_r != `SFD_PAGE_MAX) begin
                        o_pg_wr    <= 1'b1;
                        o_pg_data  <= shn[7:0];
                        o_pg_index <= pgcnt_r[7:0];
                        pgcnt_r    <= pgcnt_r + 9'h001;
                     end
                  end
               end
               ST_DONE: begin
                  bad_r <= 1'b1;
               end
               default: begin
               end
            endcase
         end else if (sclk_fall && (state_r == ST_OUT)) begin
            // drive on the falling edge, msb first
            obyte_r              <= cur_byte;
            o_dual_line_upper    <= cur_byte[pos_r];
            o_dual_line_upper_oe <= 1'b1;
            if (dout) begin
               o_dual_line_lower    <= cur_byte[pos_r - 3'h1];
               o_dual_line_lower_oe <= 1'b1;
            end
            if (last_bit) begin
               pos_r     <= 3'h7;
               o_rd_addr <= o_rd_addr + 24'h00_0001;
               if (idx_r != `SFD_IDX_MAX) begin
                  idx_r <= idx_r + 4'h1;
               end
            end else begin
               pos_r <= pos_r - (dout ? 3'h2 : 3'h1);
            end
         end
      end
   end
endmodule

// file: sim/sfd_decoder_assertions.sv
// concurrent checks on the ports of the instruction decoder
`timescale 1ns/1ns
module sfd_decoder_chk (
   input wire i_clk,
   input wire i_rst,
   input wire i_cs_n,
   input wire i_sclk,
   input wire i_busy,
   input wire o_dual_line_upper,
   input wire o_dual_line_upper_oe,
   input wire o_dual_line_lower_oe,
   input wire o_pg_wr,
   input wire o_cmd_valid,
   input wire o_power_down
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // outputs come out of reset quiet
   property p_rst_quiet;
      $fell(i_rst) |-> !o_cmd_valid && !o_pg_wr && !o_power_down && !o_dual_line_upper_oe;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
   // a command is committed only once chip select has gone high
   property p_cmd_at_desel;
      o_cmd_valid |-> $past(i_cs_n, 2) ##1 !o_cmd_valid;
   endproperty
   a_cmd_at_desel: assert property (p_cmd_at_desel) else $error("command pulse off deselect");
   // page bytes arrive only inside a selected frame, one cycle each
   property p_pg_in_frame;
      o_pg_wr |-> !i_cs_n ##1 !o_pg_wr;
   endproperty
   a_pg_in_frame: assert property (p_pg_in_frame) else $error("page write outside frame");
   // drivers released while deselected
   property p_oe_idle;
      i_cs_n [*6] |-> !o_dual_line_upper_oe && !o_dual_line_lower_oe;
   endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("line driven while deselected");
   // the lower line is only driven in two-line phases, with the upper
   property p_lower_pair;
      o_dual_line_lower_oe |-> o_dual_line_upper_oe;
   endproperty
   a_lower_pair: assert property (p_lower_pair) else $error("lower line driven alone");
   // output bits move only just after a serial clock fall
   property p_out_on_fall;
      o_dual_line_upper_oe && $past(o_dual_line_upper_oe) && $changed(o_dual_line_upper)
         |-> !$past(i_sclk, 2) || !$past(i_sclk, 3) || !$past(i_sclk, 4);
   endproperty
   a_out_on_fall: assert property (p_out_on_fall) else $error("output bit moved off a fall");
   // power-down is entered at deselect of its frame
   property p_pd_at_desel;
      $rose(o_power_down) |-> $past(i_cs_n, 2);
   endproperty
   a_pd_at_desel: assert property (p_pd_at_desel) else $error("power-down entered mid-frame");
   // nothing is committed while the core is busy
   property p_busy_block;
      o_cmd_valid |-> !i_busy;
   endproperty
   a_busy_block: assert property (p_busy_block) else $error("command taken while busy");
endmodule
bind sfd_decoder sfd_decoder_chk sfd_decoder_chk_i (.i_clk(i_clk), .i_rst(i_rst),
   .i_cs_n(i_cs_n), .i_sclk(i_sclk), .i_busy(i_busy), .o_dual_line_upper(o_dual_line_upper),
   .o_dual_line_upper_oe(o_dual_line_upper_oe), .o_dual_line_lower_oe(o_dual_line_lower_oe),
   .o_pg_wr(o_pg_wr), .o_cmd_valid(o_cmd_valid), .o_power_down(o_power_down));

// file: sim/sfd_decoder_tb_top.sv
// self-checking bench for the instruction decoder
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
   $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module sfd_decoder_tb_top;
   reg         i_clk, i_rst, i_busy;
   reg  [7:0]  i_status;
   wire        cs_n, sclk, h_lo, h_up, d_lo, d_lo_oe, d_up, d_up_oe, pg_wr, cmd_valid, pd;
   wire [23:0] rd_addr, cmd_addr;
   wire [7:0]  cmd_op, cmd_wdata, mode_bits, pg_data, pg_idx;
   wire [8:0]  cmd_count;
   integer     miscompares = 0, checks = 0, cmd_n = 0, pg_n = 0, j;
   integer     seed = 32'hd3e2;
   reg  [7:0]  lone [0:4];
   reg  [7:0]  ers [0:2];
   reg  [7:0]  r;
   // each line: the device when it drives, else the host
   wire        w_lo = d_lo_oe ? d_lo : h_lo;
   wire        w_up = d_up_oe ? d_up : h_up;
   function [7:0] mem_b(input [23:0] a);
      mem_b = a[7:0] ^ a[15:8] ^ 8'h5A;
   endfunction
   // k 0 array, 1 mfr/dev pair, 2 standard id, 3 unique id, 4 status, else device id
   function [7:0] exp_b(input [3:0] k, input [23:0] a, input integer i);
      reg [63:0] u;
      begin
         u = 64'h0123_4567_89AB_CDEF;
         case (k)
            0: exp_b = mem_b(a + i);
            1: exp_b = i[0] ? 8'h5A : 8'hA5;
            2: exp_b = (i == 0) ? 8'hA5 : (i == 1) ? 8'h3C : (i == 2) ? 8'hC3 : 8'h00;
            3: exp_b = (i < 8) ? u[63-8*i -: 8] : 8'h00;
            4: exp_b = i_status;
            default: exp_b = 8'h5A;
         endcase
      end
   endfunction
   wire [7:0] i_rd_data = mem_b(rd_addr);
   sfd_decoder sfd_decoder_i (.i_clk(i_clk), .i_rst(i_rst), .i_cs_n(cs_n), .i_sclk(sclk),
      .i_dual_line_lower(w_lo), .i_dual_line_upper(w_up), .i_busy(i_busy),
      .i_status(i_status), .i_rd_data(i_rd_data), .o_dual_line_lower(d_lo),
      .o_dual_line_lower_oe(d_lo_oe), .o_dual_line_upper(d_up), .o_dual_line_upper_oe(d_up_oe),
      .o_rd_addr(rd_addr), .o_pg_wr(pg_wr), .o_pg_data(pg_data), .o_pg_index(pg_idx),
      .o_cmd_valid(cmd_valid), .o_cmd_op(cmd_op), .o_cmd_addr(cmd_addr),
      .o_cmd_wdata(cmd_wdata), .o_cmd_count(cmd_count), .o_mode_bits(mode_bits),
      .o_power_down(pd));
   sfd_host_model sfd_host_model_i (.i_clk(i_clk), .i_lo(w_lo), .i_up(w_up), .o_cs_n(cs_n),
      .o_sclk(sclk), .o_lo(h_lo), .o_up(h_up));
   // pulse counters
   always @(posedge i_clk) begin
      if (cmd_valid === 1'b1) cmd_n++;
      if (pg_wr === 1'b1) pg_n++;
   end
   task finish_test;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // dm 0 single, 2 two-line out, 3 two-line address and mode in, two-line out
   task rd(input [7:0] op, input integer na, input integer nd, input integer dm,
           input integer n, input [3:0] k);
      reg [23:0] a;
      reg [7:0]  mb;
      integer    i;
      begin
         a = $random(seed);
         mb = $random(seed);
         if (k != 0) a = 24'h00_0000;
         sfd_host_model_i.sel;
         sfd_host_model_i.xb(op, 0, r);
         for (i = 0; i < na; i++) sfd_host_model_i.xb(a[23-8*i -: 8], (dm == 3) ? 1 : 0, r);
         if (dm == 3) sfd_host_model_i.xb(mb, 1, r);
         for (i = 0; i < nd; i++) sfd_host_model_i.xb(8'h00, 0, r);
         for (i = 0; i < n; i++) begin
            sfd_host_model_i.xb(8'h00, (dm != 0) ? 2 : 0, r);
            `CHK("read byte", exp_b(k, a, i), r)
         end
         sfd_host_model_i.desel(0);
         if (dm == 3) `CHK("mode bits", mb, mode_bits)
      end
   endtask
   // write-type frame: opcode, na address bytes, nb data bytes, stray bits
   task wr(input [7:0] op, input integer na, input integer nb, input integer ex,
           input integer ok);
      reg [23:0] a;
      reg [7:0]  d;
      reg [7:0]  dl;
      integer    i, c0, p0;
      begin
         a = $random(seed);
         d = 0;
         dl = 0;
         c0 = cmd_n;
         p0 = pg_n;
         sfd_host_model_i.sel;
         sfd_host_model_i.xb(op, 0, r);
         for (i = 0; i < na; i++) sfd_host_model_i.xb(a[23-8*i -: 8], 0, r);
         for (i = 0; i < nb; i++) begin
            d = $random(seed);
            if (i < 256) dl = d;
            sfd_host_model_i.xb(d, 0, r);
         end
         sfd_host_model_i.desel(ex);
         `CHK("cmd valid", ok, cmd_n - c0)
         if (ok == 1) begin
            `CHK("cmd op", op, cmd_op)
            if (na == 3) `CHK("cmd addr", a, cmd_addr)
            if (op == 8'h01) `CHK("cmd wdata", d, cmd_wdata)
            if (op == 8'h02) begin
               `CHK("cmd count", (nb > 256) ? 256 : nb, cmd_count)
               `CHK("page writes", (nb > 256) ? 256 : nb, pg_n - p0)
               `CHK("page data", dl, pg_data)
               `CHK("page index", ((nb > 256) ? 256 : nb) - 1, pg_idx)
            end
         end
      end
   endtask
   initial begin
      i_clk = 0;
      forever #2 i_clk = ~i_clk;
   end
   // hang guard
   initial begin
      repeat (100000) @(posedge i_clk);
      miscompares++;
      finish_test;
   end
   initial begin
      i_rst = 1;
      i_busy = 0;
      i_status = 8'h00;
      lone[0] = 8'h06; lone[1] = 8'h50; lone[2] = 8'h04; lone[3] = 8'hC7; lone[4] = 8'h60;
      ers[0] = 8'h20; ers[1] = 8'h52; ers[2] = 8'hD8;
      repeat (4) @(posedge i_clk);
      #1 i_rst = 0;
      repeat (5) @(posedge i_clk);
      #1;
      for (j = 0; j < 5; j++) wr(lone[j], 0, 0, 0, 1);
      wr(8'h06, 0, 0, 3, 0);
      wr(8'h06, 0, 1, 0, 0);
      for (j = 0; j < 3; j++) wr(ers[j], 3, 0, 0, 1);
      wr(8'h20, 3, 0, 4, 0);
      wr(8'h01, 0, 1, 0, 1);
      wr(8'h01, 0, 2, 0, 0);
      wr(8'h02, 3, 3, 0, 1);
      wr(8'h02, 3, 258, 0, 1);
      wr(8'hFF, 0, 2, 0, 0);
      for (j = 0; j < 4; j++) begin
         i_status = $random(seed);
         rd(8'h05, 0, 0, 0, 3, 4);
      end
      i_busy = 1;
      wr(8'h06, 0, 0, 0, 0);
      rd(8'h05, 0, 0, 0, 2, 4);
      i_busy = 0;
      rd(8'h03, 3, 0, 0, 4, 0);
      rd(8'h0B, 3, 1, 0, 3, 0);
      rd(8'h3B, 3, 1, 2, 3, 0);
      rd(8'hBB, 3, 0, 3, 3, 0);
      rd(8'h9F, 0, 0, 0, 4, 2);
      rd(8'h90, 3, 0, 0, 4, 1);
      rd(8'h92, 3, 0, 3, 4, 1);
      rd(8'h4B, 0, 4, 0, 9, 3);
      sfd_host_model_i.sel;
      sfd_host_model_i.xb(8'hB9, 0, r);
      sfd_host_model_i.desel(0);
      `CHK("power down", 1'b1, pd)
      wr(8'h06, 0, 0, 0, 0);
      rd(8'hAB, 3, 0, 0, 3, 5);
      `CHK("power down", 1'b0, pd)
      finish_test;
   end
endmodule

// file: sim/sfd_host_model.sv
// host controller model: frames bytes in mode 0 on one or two lines
`timescale 1ns/1ns
module sfd_host_model (
   input  wire i_clk,
   input  wire i_lo,
   input  wire i_up,
   output reg  o_cs_n,
   output reg  o_sclk,
   output reg  o_lo,
   output reg  o_up
);
   // idle: deselected, clock parked low
   initial begin
      o_cs_n = 1;
      o_sclk = 0;
      o_lo = 0;
      o_up = 0;
   end
   // half of a 48 ns serial clock period
   task half;
      repeat (6) @(posedge i_clk);
      #1;
   endtask
   task sel;
      o_cs_n = 0;
      half;
   endtask
   // m 0 single line, 1 two-line input, 2 two-line output
   task xb(input [7:0] tx, input [1:0] m, output [7:0] rx);
      integer i;
      begin
         rx = 0;
         for (i = 0; i < ((m == 0) ? 8 : 4); i++) begin
            if (m == 0) o_lo = tx[7-i];
            else begin
               o_up = tx[7-2*i];
               o_lo = tx[6-2*i];
            end
            half;
            o_sclk = 1;
            rx = (m == 0) ? {rx[6:0], i_up} : {rx[5:0], i_up, i_lo};
            half;
            o_sclk = 0;
         end
      end
   endtask
   // optional stray bits, then deselect and a gap
   task desel(input integer extra);
      integer i;
      begin
         for (i = 0; i < extra; i++) begin
            half;
            o_sclk = 1;
            half;
            o_sclk = 0;
         end
         half;
         o_cs_n = 1;
         o_lo = ~o_lo;
         o_up = ~o_up;
         repeat (10) @(posedge i_clk);
         #1;
      end
   endtask
endmodule
